//--- shared/irq_agg_params.svh
// Constants for the interrupt aggregator and its core-side bridge
`ifndef IRQ_AGG_PARAMS_SVH
`define IRQ_AGG_PARAMS_SVH

// Source counts and widths
`define IAG_LEVEL_COUNT 16
`define IAG_EDGE_COUNT 8
`define IAG_SRC_COUNT 24
`define IAG_ID_W 5
`define IAG_ADDR_W 12
`define IAG_DATA_W 8

// Device register offsets on the link
`define IAG_MASK0_OFF 12'h640
`define IAG_MASK1_OFF 12'h641
`define IAG_MASK2_OFF 12'h642
`define IAG_CTRL_OFF 12'h643
`define IAG_PRIO0_OFF 12'h644
`define IAG_PRIO1_OFF 12'h645
`define IAG_PRIO2_OFF 12'h646
`define IAG_SRC0_OFF 12'h648
`define IAG_SRC1_OFF 12'h649
`define IAG_SRC2_OFF 12'h64A

// Device field positions and reset values
`define IAG_CTRL_GIE_BIT 0
`define IAG_CTRL_MULTI_BIT 1
`define IAG_CTRL_W 2
`define IAG_EDGE_VALID 8'h7F
`define IAG_RESET_BYTE 8'h00
`define IAG_RESET_SRC 24'h000000
`define IAG_RESET_ID 5'h00

// Bridge register offsets on APB
`define BR_CMD_OFF 12'h000
`define BR_STATUS_OFF 12'h004
`define BR_INT_STATUS_OFF 12'h008
`define BR_INT_MASK_OFF 12'h00C

// Bridge field positions
`define BR_CMD_WDATA_LSB 12
`define BR_CMD_WRITE_BIT 20
`define BR_ST_BUSY_BIT 0
`define BR_ST_RDATA_LSB 8
`define BR_ST_IRQ_BIT 16
`define BR_ST_HIGH_BIT 17
`define BR_ST_ID_LSB 18
`define BR_EV_DONE_BIT 0
`define BR_EV_IRQ_BIT 1
`define BR_EV_W 2
`define BR_RESET_EV 2'h0
`define BR_RESET_WORD 32'h00000000

`endif

//--- shared/irq_agg_pkg.sv
// Types shared by both ends of the interrupt link
package irq_agg_pkg;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b01,
		HS_WAIT = 2'b10
	} bridge_state_e;
	typedef logic [4:0] source_id_t;
	typedef logic [7:0] reg_byte_t;
endpackage

//--- shared/irq_link_if.sv
// Link between the interrupt aggregator and the core-side bridge
`timescale 1ns/10ps
interface irq_link_if;
	logic req;
	logic wr;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	logic irq;
	logic irq_high;
	logic [4:0] irq_id;
	modport device (
		input req,
		input wr,
		input addr,
		input wdata,
		output rdata,
		output ack,
		output irq,
		output irq_high,
		output irq_id
	);
	modport host (
		output req,
		output wr,
		output addr,
		output wdata,
		input rdata,
		input ack,
		input irq,
		input irq_high,
		input irq_id
	);
endinterface

//--- src/irq_aggregator.sv
// Interrupt aggregator: 24 sources, masks, priorities, flags and request
`timescale 1ns/10ps
`include "irq_agg_params.svh"

// Operation
// - 24 sources: 16 level, 8 edge
// - Byte 0 maps host, serial, FIFO, DMA, timers
// - Byte 1 maps key engine, PWM, radio, USB
// - Byte 2 maps pins, timers, USB; bit7 reserved
// - Mask one enables source; masks reset zero
// - Control bit 0 gates all requests
// - Control bit 1 is plain storage
// - Priority bytes, one selects high, reset zero
// - High priority requests presented before low
// - Software leaves priorities at reset values
// - Requesting source sets its flag bit
// - Flag word puts byte 2 on top
// - Edge flag held until one written
// - Level flag follows source module status
// - Core suspends, services, then resumes
// - Software masks, enables, then reads flags
module irq_aggregator
	import irq_agg_pkg::*;
#(
	parameter int LEVEL_COUNT = `IAG_LEVEL_COUNT,
	parameter int EDGE_COUNT = `IAG_EDGE_COUNT
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Core-facing link
	irq_link_if.device link,
	// Level sources, status of their modules
	input wire logic [LEVEL_COUNT-1:0] level_src,
	// Edge sources, set on rising edge
	input wire logic [EDGE_COUNT-1:0] edge_src
);

	localparam int SRC_COUNT = LEVEL_COUNT + EDGE_COUNT;
	localparam logic [7:0] EDGE_VALID = `IAG_EDGE_VALID;

	// The byte map below is fixed; other counts cannot be served
	if (LEVEL_COUNT != `IAG_LEVEL_COUNT || EDGE_COUNT != `IAG_EDGE_COUNT) begin : g_bad
		$error("irq_aggregator needs 16 level and 8 edge sources");
	end

	// Register state
	logic [SRC_COUNT-1:0] mask_q;
	logic [SRC_COUNT-1:0] mask_d;
	logic [SRC_COUNT-1:0] prio_q;
	logic [SRC_COUNT-1:0] prio_d;
	logic [`IAG_CTRL_W-1:0] ctrl_q;
	logic [`IAG_CTRL_W-1:0] ctrl_d;

	// Flag state
	logic [LEVEL_COUNT-1:0] level_flag_q;
	logic [EDGE_COUNT-1:0] edge_flag_q;
	logic [EDGE_COUNT-1:0] edge_flag_d;
	logic [EDGE_COUNT-1:0] edge_prev_q;
	logic [EDGE_COUNT-1:0] edge_set;
	logic [EDGE_COUNT-1:0] edge_clr;

	// Link answer and request outputs
	logic ack_q;
	reg_byte_t rdata_q;
	reg_byte_t rdata_d;
	logic irq_q;
	logic irq_high_q;
	source_id_t irq_id_q;

	// Request decode
	logic take;
	logic wr;
	logic hit_m0;
	logic hit_m1;
	logic hit_m2;
	logic hit_ctrl;
	logic hit_p0;
	logic hit_p1;
	logic hit_p2;
	logic hit_s0;
	logic hit_s1;
	logic hit_s2;

	// Request selection
	logic [SRC_COUNT-1:0] flags;
	logic [SRC_COUNT-1:0] active;
	logic [SRC_COUNT-1:0] hi_active;
	logic [SRC_COUNT-1:0] lo_active;
	logic any_active;
	logic any_high;
	source_id_t sel_id;

	// Lowest index of a set bit, zero when none
	function automatic source_id_t pick_lowest(input logic [SRC_COUNT-1:0] v);
		source_id_t id;
		id = `IAG_RESET_ID;
		for (int i = SRC_COUNT - 1; i >= 0; i--) begin
			if (v[i]) begin
				id = source_id_t'(i);
			end
		end
		return id;
	endfunction

	// A request is taken once; the ack cycle blocks a second take
	assign take = link.req & ~ack_q;
	assign wr = take & link.wr;

	// Address decode
	assign hit_m0 = link.addr == `IAG_MASK0_OFF;
	assign hit_m1 = link.addr == `IAG_MASK1_OFF;
	assign hit_m2 = link.addr == `IAG_MASK2_OFF;
	assign hit_ctrl = link.addr == `IAG_CTRL_OFF;
	assign hit_p0 = link.addr == `IAG_PRIO0_OFF;
	assign hit_p1 = link.addr == `IAG_PRIO1_OFF;
	assign hit_p2 = link.addr == `IAG_PRIO2_OFF;
	assign hit_s0 = link.addr == `IAG_SRC0_OFF;
	assign hit_s1 = link.addr == `IAG_SRC1_OFF;
	assign hit_s2 = link.addr == `IAG_SRC2_OFF;

	// Mask bytes: level bytes 0 and 1, edge byte 2 without bit 7
	assign mask_d[7:0] = (wr & hit_m0) ? link.wdata : mask_q[7:0];
	assign mask_d[15:8] = (wr & hit_m1) ? link.wdata : mask_q[15:8];
	assign mask_d[23:16] = (wr & hit_m2) ? (link.wdata & EDGE_VALID) : mask_q[23:16];

	// Priority bytes share the mask layout
	assign prio_d[7:0] = (wr & hit_p0) ? link.wdata : prio_q[7:0];
	assign prio_d[15:8] = (wr & hit_p1) ? link.wdata : prio_q[15:8];
	assign prio_d[23:16] = (wr & hit_p2) ? (link.wdata & EDGE_VALID) : prio_q[23:16];

	// Control: global enable and a storage bit
	assign ctrl_d = (wr & hit_ctrl) ? link.wdata[`IAG_CTRL_W-1:0] : ctrl_q;

	// Per-bit edge capture; a new edge outranks a clearing write
	for (genvar g = 0; g < EDGE_COUNT; g++) begin : g_edge
		assign edge_set[g] = edge_src[g] & ~edge_prev_q[g] & EDGE_VALID[g];
		assign edge_clr[g] = wr & hit_s2 & link.wdata[g];
		assign edge_flag_d[g] = edge_set[g] | (edge_flag_q[g] & ~edge_clr[g]);
	end

	// Flag word: edge byte on top, timer 0 at bit 0
	assign flags = {edge_flag_q, level_flag_q};
	assign active = flags & mask_q;
	assign hi_active = active & prio_q;
	assign lo_active = active & ~prio_q;
	assign any_active = |active;
	assign any_high = |hi_active;
	assign sel_id = any_high ? pick_lowest(hi_active) : pick_lowest(lo_active);

	// Read selection; unmapped offsets read as zero
	assign rdata_d = hit_m0 ? mask_q[7:0] :
		hit_m1 ? mask_q[15:8] :
		hit_m2 ? mask_q[23:16] :
		hit_ctrl ? reg_byte_t'(ctrl_q) :
		hit_p0 ? prio_q[7:0] :
		hit_p1 ? prio_q[15:8] :
		hit_p2 ? prio_q[23:16] :
		hit_s0 ? flags[7:0] :
		hit_s1 ? flags[15:8] :
		hit_s2 ? flags[23:16] :
		`IAG_RESET_BYTE;

	// Software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= `IAG_RESET_SRC;
			prio_q <= `IAG_RESET_SRC;
			ctrl_q <= '0;
		end else begin
			mask_q <= mask_d;
			prio_q <= prio_d;
			ctrl_q <= ctrl_d;
		end
	end

	// Source flags: level flags track status, edge flags are sticky
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_flag_q <= '0;
			edge_flag_q <= '0;
			edge_prev_q <= '0;
		end else begin
			level_flag_q <= level_src;
			edge_flag_q <= edge_flag_d;
			edge_prev_q <= edge_src;
		end
	end

	// Link answer one cycle after a take
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= 1'b0;
			rdata_q <= `IAG_RESET_BYTE;
		end else begin
			ack_q <= take;
			if (take) begin
				rdata_q <= link.wr ? `IAG_RESET_BYTE : rdata_d;
			end
		end
	end

	// Request line with the winning source and its class
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
			irq_high_q <= 1'b0;
			irq_id_q <= `IAG_RESET_ID;
		end else begin
			irq_q <= ctrl_q[`IAG_CTRL_GIE_BIT] & any_active;
			irq_high_q <= ctrl_q[`IAG_CTRL_GIE_BIT] & any_high;
			irq_id_q <= sel_id;
		end
	end

	// Link outputs
	assign link.ack = ack_q;
	assign link.rdata = rdata_q;
	assign link.irq = irq_q;
	assign link.irq_high = irq_high_q;
	assign link.irq_id = irq_id_q;

endmodule

//--- src/irq_core_bridge.sv
// Core-side bridge: APB orders become link accesses; link request raises an interrupt
`timescale 1ns/10ps
`include "irq_agg_params.svh"

module irq_core_bridge
	import irq_agg_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt to software
	output logic irq,
	// Aggregator link
	irq_link_if.host link
);

	bridge_state_e state_q;
	bridge_state_e state_d;
	logic req_q;
	logic wr_q;
	logic [11:0] addr_q;
	reg_byte_t wdata_q;
	reg_byte_t last_rdata_q;
	logic link_irq_prev_q;
	logic [`BR_EV_W-1:0] ev_status_q;
	logic [`BR_EV_W-1:0] ev_mask_q;
	logic [`BR_EV_W-1:0] ev_set;
	logic [`BR_EV_W-1:0] ev_clr;
	logic [31:0] prdata_q;
	logic [31:0] rd_word;
	logic [31:0] status_word;
	logic setup;
	logic apb_wr;
	logic hit_cmd;
	logic hit_status;
	logic hit_int_status;
	logic hit_int_mask;
	logic start;
	logic done;

	// APB phase and address decode
	assign setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite;
	assign hit_cmd = paddr == `BR_CMD_OFF;
	assign hit_status = paddr == `BR_STATUS_OFF;
	assign hit_int_status = paddr == `BR_INT_STATUS_OFF;
	assign hit_int_mask = paddr == `BR_INT_MASK_OFF;

	// A command starts only when idle; one while busy is dropped
	assign start = apb_wr & hit_cmd & (state_q == HS_IDLE);
	assign done = (state_q == HS_WAIT) & link.ack;

	// Events: access finished, link request rose; set beats clear
	assign ev_set[`BR_EV_DONE_BIT] = done;
	assign ev_set[`BR_EV_IRQ_BIT] = link.irq & ~link_irq_prev_q;
	assign ev_clr = (apb_wr & hit_int_status) ? pwdata[`BR_EV_W-1:0] : '0;

	// Status word
	assign status_word = (32'(state_q == HS_WAIT) << `BR_ST_BUSY_BIT)
		| (32'(last_rdata_q) << `BR_ST_RDATA_LSB)
		| (32'(link.irq) << `BR_ST_IRQ_BIT)
		| (32'(link.irq_high) << `BR_ST_HIGH_BIT)
		| (32'(link.irq_id) << `BR_ST_ID_LSB);

	// Read selection; unmapped offsets read as zero
	assign rd_word = hit_status ? status_word :
		hit_int_status ? 32'(ev_status_q) :
		hit_int_mask ? 32'(ev_mask_q) :
		`BR_RESET_WORD;

	// Next link state
	always_comb begin
		state_d = state_q;
		case (state_q)
			HS_IDLE: begin
				if (start) begin
					state_d = HS_WAIT;
				end
			end
			HS_WAIT: begin
				if (link.ack) begin
					state_d = HS_IDLE;
				end
			end
			default: begin
				state_d = HS_IDLE;
			end
		endcase
	end

	// Link request held until the aggregator answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= HS_IDLE;
			req_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			last_rdata_q <= '0;
		end else begin
			state_q <= state_d;
			if (start) begin
				req_q <= 1'b1;
				wr_q <= pwdata[`BR_CMD_WRITE_BIT];
				addr_q <= pwdata[11:0];
				wdata_q <= pwdata[`BR_CMD_WDATA_LSB +: 8];
			end else if (done) begin
				req_q <= 1'b0;
				last_rdata_q <= link.rdata;
			end
		end
	end

	// Interrupt status, mask and read data capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_status_q <= `BR_RESET_EV;
			ev_mask_q <= `BR_RESET_EV;
			link_irq_prev_q <= 1'b0;
			prdata_q <= `BR_RESET_WORD;
		end else begin
			ev_status_q <= ev_set | (ev_status_q & ~ev_clr);
			link_irq_prev_q <= link.irq;
			if (apb_wr & hit_int_mask) begin
				ev_mask_q <= pwdata[`BR_EV_W-1:0];
			end
			if (setup) begin
				prdata_q <= rd_word;
			end
		end
	end

	// Outputs
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = |(ev_status_q & ev_mask_q);
	assign link.req = req_q;
	assign link.wr = wr_q;
	assign link.addr = addr_q;
	assign link.wdata = wdata_q;

endmodule

//--- dv/irq_link_chk.sv
// Assertions on the link between the aggregator and the core-side bridge
`timescale 1ns/10ps
module irq_link_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic req,
	input wire logic wr,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic irq,
	input wire logic irq_high,
	input wire logic [4:0] irq_id
);
	logic gie_q;
	// Request taken, and a write of the control byte
	wire take = req && !ack;
	wire ctrl_wr = take && wr && addr == 12'h643;
	// Shadow of the global enable as written over the link
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gie_q <= 1'b0;
		else if (ctrl_wr)
			gie_q <= wdata[0];
	end
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	ack_one_cycle_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	ack_after_take_a: assert property (take |=> ack)
		else $error("ack missing after request");
	ack_needs_req_a: assert property (ack |-> $past(req))
		else $error("ack without request");
	req_held_a: assert property (take |=> req && $stable({wr, addr, wdata}))
		else $error("request changed before ack");
	req_drop_a: assert property (ack |=> !req)
		else $error("request held after ack");
	rsvd_bit_a: assert property (
		take && !wr && (addr == 12'h642 || addr == 12'h646) ##1 ack |-> !rdata[7])
		else $error("reserved bit reads one");
	gie_gate_a: assert property (!gie_q |=> !irq)
		else $error("request while disabled");
	high_in_irq_a: assert property (irq_high |-> irq)
		else $error("high class without request");
	id_idle_a: assert property ($past(gie_q) && !irq |-> irq_id == 5'h00)
		else $error("source index without request");
	id_range_a: assert property (irq_id <= 5'h16)
		else $error("source index out of range");
endmodule

//--- dv/tb_interrupt_aggregator_24src.sv
// Testbench joining the aggregator and the bridge, driven over APB
`timescale 1ns/10ps
`include "irq_agg_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module tb_interrupt_aggregator_24src import irq_agg_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [15:0] level_src = 16'h0000;
	logic [7:0] edge_src = 8'h00;
	int miscompares = 0;
	int checks_done = 0;
	logic [31:0] rd;
	reg_byte_t b;
	logic [23:0] f;
	// Clock, ends and checker
	always #25 pclk = ~pclk;
	irq_link_if link();
	irq_aggregator irq_aggregator_i(.pclk, .presetn, .link(link.device), .level_src, .edge_src);
	irq_core_bridge irq_core_bridge_i(.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .irq, .link(link.host));
	irq_link_chk irq_link_chk_i(.pclk, .presetn, .req(link.req), .wr(link.wr),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
		.irq(link.irq), .irq_high(link.irq_high), .irq_id(link.irq_id));
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One link byte access through the bridge, polled until not busy
	task automatic acc(input logic w, input logic [11:0] a, input reg_byte_t d,
		output reg_byte_t q);
		logic [31:0] s;
		apb(1'b1, `BR_CMD_OFF, {11'h000, w, d, a}, s);
		s = 32'h1;
		while (s[`BR_ST_BUSY_BIT] !== 1'b0)
			apb(1'b0, `BR_STATUS_OFF, 32'h0, s);
		q = s[15:8];
	endtask
	// Flag word from the three flag bytes
	task automatic flags(output logic [23:0] v);
		reg_byte_t x;
		for (int i = 0; i < 3; i++) begin
			acc(1'b0, 12'(`IAG_SRC0_OFF + i), 8'h00, x);
			v[8*i +: 8] = x;
		end
	endtask
	task automatic t_reset();
		for (int i = 0; i < 11; i++) begin
			acc(1'b0, 12'(`IAG_MASK0_OFF + i), 8'h00, b);
			`CHK(b, 8'h00)
		end
		`CHK(link.irq, 1'b0)
		$display("t_reset done");
	endtask
	task automatic t_regs();
		reg_byte_t ex [10] = '{8'hFF, 8'hFF, 8'h7F, 8'h03, 8'hFF, 8'hFF, 8'h7F, 8'h00,
			8'h00, 8'h00};
		for (int i = 0; i < 10; i++)
			acc(1'b1, 12'(`IAG_MASK0_OFF + i), 8'hFF, b);
		for (int i = 0; i < 10; i++) begin
			acc(1'b0, 12'(`IAG_MASK0_OFF + i), 8'h00, b);
			`CHK(b, ex[i])
		end
		for (int i = 0; i < 7; i++)
			acc(1'b1, 12'(`IAG_MASK0_OFF + i), 8'h00, b);
		$display("t_regs done");
	endtask
	task automatic t_level();
		acc(1'b1, `IAG_MASK0_OFF, 8'hFF, b);
		acc(1'b1, `IAG_MASK1_OFF, 8'hFF, b);
		acc(1'b1, `IAG_CTRL_OFF, 8'h01, b);
		for (int i = 0; i < 16; i++) begin
			level_src <= 16'h1 << i;
			flags(f);
			@(negedge pclk);
			`CHK(f, 24'h1 << i)
			`CHK(link.irq, 1'b1)
		end
		level_src <= 16'h0000;
		flags(f);
		`CHK(f, 24'h0)
		acc(1'b1, `IAG_MASK0_OFF, 8'h00, b);
		level_src <= 16'h0001;
		acc(1'b1, `IAG_SRC0_OFF, 8'h00, b);
		flags(f);
		@(negedge pclk);
		`CHK(f, 24'h1)
		`CHK(link.irq, 1'b0)
		acc(1'b1, `IAG_MASK0_OFF, 8'hFF, b);
		acc(1'b1, `IAG_CTRL_OFF, 8'h00, b);
		@(negedge pclk);
		`CHK(link.irq, 1'b0)
		acc(1'b1, `IAG_CTRL_OFF, 8'h01, b);
		@(negedge pclk);
		`CHK(link.irq, 1'b1)
		$display("t_level done");
	endtask
	task automatic t_edge();
		level_src <= 16'h0000;
		acc(1'b1, `IAG_MASK2_OFF, 8'hFF, b);
		for (int i = 0; i < 8; i++) begin
			edge_src <= 8'h1 << i;
			@(posedge pclk);
			edge_src <= 8'h00;
			flags(f);
			`CHK(f, (i == 7) ? 24'h0 : 24'h1 << (16 + i))
			acc(1'b1, `IAG_SRC2_OFF, 8'h1 << i, b);
			flags(f);
			`CHK(f, 24'h0)
		end
		// A clearing write taken at the same edge as a new rise leaves the flag set
		apb(1'b1, `BR_CMD_OFF, {11'h000, 1'b1, 8'h01, `IAG_SRC2_OFF}, rd);
		edge_src <= 8'h01;
		@(posedge pclk);
		edge_src <= 8'h00;
		flags(f);
		`CHK(f, 24'h010000)
		acc(1'b1, `IAG_SRC2_OFF, 8'h01, b);
		flags(f);
		`CHK(f, 24'h0)
		$display("t_edge done");
	endtask
	task automatic t_prio();
		level_src <= 16'h0028;
		acc(1'b1, `IAG_MASK2_OFF, 8'h00, b);
		apb(1'b0, `BR_STATUS_OFF, 32'h0, rd);
		`CHK(rd[22:16], 7'h0D)
		acc(1'b1, `IAG_PRIO0_OFF, 8'h20, b);
		apb(1'b0, `BR_STATUS_OFF, 32'h0, rd);
		`CHK(rd[22:16], 7'h17)
		acc(1'b1, `IAG_PRIO0_OFF, 8'h00, b);
		$display("t_prio done");
	endtask
	task automatic t_bridge();
		level_src <= 16'h0000;
		flags(f);
		apb(1'b1, `BR_INT_STATUS_OFF, 32'h3, rd);
		apb(1'b1, `BR_INT_MASK_OFF, 32'h2, rd);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		level_src <= 16'h0001;
		flags(f);
		@(negedge pclk);
		`CHK(irq, 1'b1)
		apb(1'b0, `BR_INT_STATUS_OFF, 32'h0, rd);
		`CHK(rd, 32'h00000003)
		apb(1'b1, `BR_INT_STATUS_OFF, 32'h2, rd);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b0, 12'h010, 32'h0, rd);
		`CHK({pslverr, rd}, 33'h0)
		$display("t_bridge done");
	endtask
	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		#1000000;
		miscompares++;
		test_done();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_level();
		t_edge();
		t_prio();
		t_bridge();
		test_done();
	end
endmodule
